// >>> rss_pkg.sv
package rss_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int CLK_NS       = 100;
   localparam int CLK_KHZ      = 10000;
   localparam int STRAP_NS     = 10000;
   localparam int STRAP_CYC    = (STRAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_NS     = 100;
   localparam int PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLAVE_KHZ    = 250;
   localparam int SLAVE_CYC    = CLK_KHZ / SLAVE_KHZ;
   localparam int HOLD_KHZ     = 275;
   // gap count that ends slave mode when no edge comes with it, rounded down
   localparam int HOLD_CYC     = CLK_KHZ / HOLD_KHZ;
   localparam int ENTRY_EDGES  = 10;
   localparam int SPREAD_PCT   = 10;
   localparam int DELAY_RST    = 1000;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_DELAY  = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_IRQ    = 8'h0c;
   localparam logic [7:0] A_MASK   = 8'h10;
   localparam int IRQ_W       = 4;
   localparam int IRQ_SLAVE   = 0;
   localparam int IRQ_MASTER  = 1;
   localparam int IRQ_PGOOD   = 2;
   localparam int IRQ_PFAIL   = 3;

   // ****************************************
   // strap tables
   // ****************************************
   localparam int FSW_KHZ [8] = '{250, 300, 400, 500, 600, 800, 1000, 1250};

   typedef enum logic {RSS_QUIET, RSS_SAVING} rss_light_t;

   typedef struct packed {
      rss_light_t light;
      logic [1:0] thr;
   } rss_mode_t;

   // thr: 0 = 80 %, 1 = 87 %, 2 = 93 %, 3 = 96 %; codes 0 and 7 are the no-resistor states
   localparam rss_mode_t MODE_TAB [8] = '{
      '{RSS_QUIET, 2'h2}, '{RSS_QUIET, 2'h0}, '{RSS_QUIET, 2'h1}, '{RSS_QUIET, 2'h3},
      '{RSS_SAVING, 2'h0}, '{RSS_SAVING, 2'h1}, '{RSS_SAVING, 2'h3}, '{RSS_SAVING, 2'h2}};

   typedef struct packed {
      logic [21:0] zero;
      logic        running;
      logic        slave;
      logic        latched;
      logic        pgood;
      rss_mode_t   mode;
      logic [2:0]  fsw;
   } rss_status_t;

   function automatic logic [15:0] rss_period(input logic [2:0] code);
      return 16'(CLK_KHZ / FSW_KHZ[code]);
   endfunction : rss_period

   // an edge gap shorter than this is faster than the oscillator's widest spread
   function automatic logic [15:0] rss_fast_period(input logic [2:0] code);
      return 16'((CLK_KHZ * 100) / (FSW_KHZ[code] * (100 + SPREAD_PCT)));
   endfunction : rss_fast_period

endpackage : rss_pkg

// >>> rss_sync.sv
`timescale 1ns/1ps
module rss_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // bits from outside the domain
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta[i] <= 1'b0;
               q[i]    <= 1'b0;
            end else begin
               meta[i] <= d[i];
               q[i]    <= meta[i];
            end
         end
      end
   endgenerate
endmodule : rss_sync

// >>> rss_osc.sv
`timescale 1ns/1ps
module rss_osc (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // control
   input  wire logic        run,
   input  wire logic        restart,
   input  wire logic [15:0] period,
   // one-cycle pulse at each period start
   output logic             tick
);
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic        next_tick;

   always_comb begin
      next_cnt  = cnt;
      next_tick = 1'b0;
      if (!run || restart) begin
         next_cnt = 16'h0001;
      end else if (cnt >= period - 16'h0001) begin
         next_cnt  = 16'h0000;
         next_tick = 1'b1;
      end else begin
         next_cnt = cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt  <= 16'h0000;
         tick <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule : rss_osc

// >>> rss_top.sv
`timescale 1ns/1ps
// Overview of operation
// R1: straps are sampled once after reset, before soft-start is enabled
// R2: frequency strap pin is biased while sampled, then left floating
// R3: mode strap picks quiet or saving light load and one of four thresholds
// R4: no-resistor mode strap codes decode to the two 93 % settings
// R5: reset output held low while output is below the chosen threshold
// R6: reset output released only when the delay reaches its end level
// R7: delay is a programmable count restarted whenever output leaves regulation
// R8: by default act as master and pulse the sync line at strap frequency
// R9: as slave run the oscillator at 250 kHz and follow the sync reference
// R10: enter slave only after 10 edge gaps faster than oscillator spread
// R11: stay slave while edges exceed 275 kHz, else one 250 kHz pulse then master
// R12: with peer devices, slaves switch half a period after the master
// R13: with an external reference, switching aligns to the reference edge
// R14: sync line low during strap sampling latches slave mode until reset
// R15: external master drives 275 kHz to 1.4 MHz with pulses of 100 ns or more
// R16: external master should stay within 20 % of the strap frequency
// R17: slope compensation fixed from the frequency strap and never changed
module rss_top
   import rss_pkg::*;
(
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   // strap pins
   input  wire logic [2:0]  fsw_strap_code,
   input  wire logic [2:0]  mode_threshold_strap,
   output logic             fsw_pin_o,
   output logic             fsw_pin_oe,
   // supervisor
   input  wire logic [3:0]  output_sense,
   output logic             reset_pin_o,
   output logic             reset_pin_oe,
   // sync line
   input  wire logic        shared_sync_line_i,
   output logic             shared_sync_line_o,
   output logic             shared_sync_line_oe,
   // to the power stage
   output logic             soft_start_en,
   output logic             sw_start,
   output logic             quiet_fixed_frequency_mode,
   output logic             light_load_saving_mode,
   output logic [2:0]       slope_sel
);

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [2:0] s_fsw;
   logic [2:0] s_mode;
   logic [3:0] s_sense;
   logic       s_sync;

   rss_sync #(.W(11)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({fsw_strap_code, mode_threshold_strap, output_sense, shared_sync_line_i}),
      .q       ({s_fsw, s_mode, s_sense, s_sync})
   );

   // ****************************************
   // strap sampling
   // ****************************************
   typedef enum logic [1:0] {PH_IDLE, PH_STRAP, PH_RUN} rss_phase_t;
   rss_phase_t ph, next_ph;
   logic [15:0] strap_cnt, next_strap_cnt;
   logic [2:0]  fsw_code, next_fsw_code;
   rss_mode_t   mode, next_mode;
   logic        latched, next_latched;

   always_comb begin
      next_ph        = ph;
      next_strap_cnt = strap_cnt;
      next_fsw_code  = fsw_code;
      next_mode      = mode;
      next_latched   = latched;
      case (ph)
         PH_IDLE: begin
            next_ph        = PH_STRAP;
            next_strap_cnt = 16'h0000;
            next_latched   = 1'b0;
         end
         PH_STRAP: begin
            next_strap_cnt = strap_cnt + 16'h0001;
            // the synchroniser still shows its reset level in the first strap cycle;
            // any low level seen after that latches slave mode [R14]
            if (!s_sync && strap_cnt != 16'h0000) begin
               next_latched = 1'b1;
            end
            if (strap_cnt == 16'(STRAP_CYC - 1)) begin
               next_fsw_code = s_fsw;                 // [R1] [R17]
               next_mode     = MODE_TAB[s_mode];      // [R3] [R4]
               next_ph       = PH_RUN;
            end
         end
         PH_RUN: next_ph = PH_RUN;
         default: next_ph = PH_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph        <= PH_IDLE;
         strap_cnt <= 16'h0000;
         fsw_code  <= 3'h0;
         mode      <= MODE_TAB[0];
         latched   <= 1'b0;
      end else begin
         ph        <= next_ph;
         strap_cnt <= next_strap_cnt;
         fsw_code  <= next_fsw_code;
         mode      <= next_mode;
         latched   <= next_latched;
      end
   end

   // ****************************************
   // sync master / slave
   // ****************************************
   typedef enum logic [1:0] {MS_MASTER, MS_SLAVE, MS_REVERT} rss_ms_t;
   rss_ms_t     ms, next_ms;
   logic        run;
   logic        peer;
   logic        sync_d;
   logic [2:0]  own_hist;
   logic        ext_rise;
   logic [15:0] gap_cnt, next_gap_cnt;
   logic [3:0]  fast_cnt, next_fast_cnt;
   logic [15:0] half_cnt, next_half_cnt;
   logic [15:0] pulse_cnt, next_pulse_cnt;
   logic [15:0] osc_per;
   logic        osc_tick;
   logic        osc_restart;
   logic        next_sw;

   assign run = (ph == PH_RUN);
   // own pulses echo back through the synchroniser; ignore edges while they can
   assign ext_rise = s_sync && !sync_d && (own_hist == 3'b000);
   // slave oscillator runs at 250 kHz, master at the strap frequency [R9] [R8]
   assign osc_per = (latched || ms != MS_MASTER) ? 16'(SLAVE_CYC) : rss_period(fsw_code);

   rss_osc u_osc (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run),
      .restart (osc_restart),
      .period  (osc_per),
      .tick    (osc_tick)
   );

   always_comb begin
      next_ms        = ms;
      next_gap_cnt   = (gap_cnt == 16'hffff) ? gap_cnt : gap_cnt + 16'h0001;
      next_fast_cnt  = fast_cnt;
      next_half_cnt  = (half_cnt == 16'h0000) ? half_cnt : half_cnt - 16'h0001;
      next_pulse_cnt = (pulse_cnt == 16'h0000) ? pulse_cnt : pulse_cnt - 16'h0001;
      next_sw        = 1'b0;
      osc_restart    = 1'b0;
      if (ext_rise) begin
         next_gap_cnt = 16'h0000;
      end
      if (run) begin
         case (ms)
            MS_MASTER: begin
               if (latched) begin
                  next_ms = MS_SLAVE;                           // [R14]
               end else if (ext_rise) begin
                  // count consecutive gaps faster than the widest spread [R10]
                  if (gap_cnt < rss_fast_period(fsw_code)) begin
                     next_fast_cnt = fast_cnt + 4'h1;
                  end else begin
                     next_fast_cnt = 4'h0;
                  end
                  if (gap_cnt < rss_fast_period(fsw_code) && fast_cnt == 4'(ENTRY_EDGES - 1)) begin
                     next_ms     = MS_SLAVE;                    // [R10]
                     osc_restart = 1'b1;
                  end
               end else if (osc_tick) begin
                  next_pulse_cnt = 16'(PULSE_CYC);              // [R8]
                  next_sw        = 1'b1;
               end
            end
            MS_SLAVE: begin
               next_fast_cnt = 4'h0;
               if (ext_rise) begin
                  if (peer) begin
                     // gap_cnt is one short of the edge spacing
                     next_half_cnt = {1'b0, gap_cnt[15:1]} + 16'h0001; // [R12]
                  end else begin
                     next_sw     = 1'b1;                        // [R13]
                     osc_restart = 1'b1;
                  end
               end else if (half_cnt == 16'h0001) begin
                  next_sw = 1'b1;                               // [R12]
               end else if (gap_cnt >= 16'(HOLD_CYC)) begin
                  if (latched) begin
                     next_sw = osc_tick;                        // [R14]
                  end else begin
                     // no edge fast enough: give one 250 kHz pulse [R11]
                     next_ms        = MS_REVERT;
                     osc_restart    = 1'b1;
                     next_pulse_cnt = 16'(PULSE_CYC);
                     next_sw        = 1'b1;
                  end
               end
            end
            MS_REVERT: begin
               if (osc_tick) begin
                  next_ms     = MS_MASTER;                      // [R11]
                  osc_restart = 1'b1;
               end
            end
            default: next_ms = MS_MASTER;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms        <= MS_MASTER;
         sync_d    <= 1'b0;
         own_hist  <= 3'b000;
         gap_cnt   <= 16'hffff;
         fast_cnt  <= 4'h0;
         half_cnt  <= 16'h0000;
         pulse_cnt <= 16'h0000;
         sw_start  <= 1'b0;
      end else begin
         ms        <= next_ms;
         sync_d    <= s_sync;
         own_hist  <= {own_hist[1:0], shared_sync_line_o};
         gap_cnt   <= next_gap_cnt;
         fast_cnt  <= next_fast_cnt;
         half_cnt  <= next_half_cnt;
         pulse_cnt <= next_pulse_cnt;
         sw_start  <= next_sw;
      end
   end

   // ****************************************
   // pins and power-stage outputs
   // ****************************************
   logic next_sync_o;
   logic next_sync_oe;

   always_comb begin
      next_sync_o  = (next_pulse_cnt != 16'h0000);
      // master owns the line; a slave listens except for its parting pulse
      next_sync_oe = (next_ph == PH_RUN) && (next_ms != MS_SLAVE);   // [R8] [R11]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_sync_line_o         <= 1'b0;
         shared_sync_line_oe        <= 1'b0;
         fsw_pin_o                  <= 1'b0;
         fsw_pin_oe                 <= 1'b0;
         soft_start_en              <= 1'b0;
         slope_sel                  <= 3'h0;
         quiet_fixed_frequency_mode <= 1'b0;
         light_load_saving_mode     <= 1'b0;
      end else begin
         shared_sync_line_o         <= next_sync_o;
         shared_sync_line_oe        <= next_sync_oe;
         fsw_pin_o                  <= (next_ph == PH_STRAP);
         fsw_pin_oe                 <= (next_ph == PH_STRAP);            // [R2]
         soft_start_en              <= (next_ph == PH_RUN);              // [R1]
         slope_sel                  <= next_fsw_code;                    // [R17]
         quiet_fixed_frequency_mode <= run && (mode.light == RSS_QUIET);   // [R3]
         light_load_saving_mode     <= run && (mode.light == RSS_SAVING);  // [R3]
      end
   end

   // ****************************************
   // output supervisor
   // ****************************************
   logic        in_reg;
   logic [15:0] dly_reg;
   logic [15:0] dly_cnt, next_dly_cnt;
   logic        next_rst_oe;

   assign in_reg = run && s_sense[mode.thr];

   always_comb begin
      next_dly_cnt = dly_cnt;
      next_rst_oe  = reset_pin_oe;
      if (!in_reg) begin
         next_dly_cnt = 16'h0000;                        // [R7]
         next_rst_oe  = 1'b1;                            // [R5]
      end else if (dly_cnt >= dly_reg) begin
         // count end stands for the ramp reaching its end level
         next_rst_oe = 1'b0;                             // [R6]
      end else begin
         next_dly_cnt = dly_cnt + 16'h0001;              // [R7]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_cnt      <= 16'h0000;
         reset_pin_oe <= 1'b1;
         reset_pin_o  <= 1'b0;
      end else begin
         dly_cnt      <= next_dly_cnt;
         reset_pin_oe <= next_rst_oe;
         reset_pin_o  <= 1'b0;
      end
   end

   // ****************************************
   // apb registers and interrupt
   // ****************************************
   logic             setup;
   logic             access;
   logic             mapped;
   logic [IRQ_W-1:0] irq_stat, next_irq_stat;
   logic [IRQ_W-1:0] irq_mask, next_irq_mask;
   logic [IRQ_W-1:0] events;
   logic [15:0]      next_dly_reg;
   logic             next_peer;
   logic [31:0]      next_prdata;
   rss_status_t      status;

   assign setup  = psel && !penable;
   assign access = psel && penable && pready;
   assign mapped = (paddr == A_CTRL) || (paddr == A_DELAY) || (paddr == A_STATUS) ||
                   (paddr == A_IRQ) || (paddr == A_MASK);
   assign events = {reset_pin_oe && !next_rst_oe ? 1'b0 : (!reset_pin_oe && next_rst_oe),
                    reset_pin_oe && !next_rst_oe,
                    ms != MS_MASTER && next_ms == MS_MASTER,
                    ms == MS_MASTER && next_ms == MS_SLAVE};
   assign status = '{zero: '0, running: run, slave: (ms == MS_SLAVE), latched: latched,
                     pgood: !reset_pin_oe, mode: mode, fsw: fsw_code};

   always_comb begin
      next_prdata   = prdata;
      next_peer     = peer;
      next_dly_reg  = dly_reg;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (setup) begin
         case (paddr)
            A_CTRL:   next_prdata = {31'h0, peer};
            A_DELAY:  next_prdata = {16'h0, dly_reg};
            A_STATUS: next_prdata = status;
            A_IRQ:    next_prdata = {28'h0, irq_stat};
            A_MASK:   next_prdata = {28'h0, irq_mask};
            default:  next_prdata = 32'h0;
         endcase
      end
      if (access && pwrite) begin
         case (paddr)
            A_CTRL:  next_peer     = pwdata[0];
            A_DELAY: next_dly_reg  = pwdata[15:0];
            A_MASK:  next_irq_mask = pwdata[IRQ_W-1:0];
            default: next_peer     = peer;
         endcase
      end
      if (access && !pwrite && paddr == A_IRQ) begin
         next_irq_stat = 4'h0;
      end
      // a new event beats the read that clears it
      next_irq_stat = next_irq_stat | events;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata   <= 32'h0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         peer     <= 1'b0;
         dly_reg  <= 16'(DELAY_RST);
         irq_mask <= 4'h0;
         irq_stat <= 4'h0;
         irq      <= 1'b0;
      end else begin
         prdata   <= next_prdata;
         pready   <= 1'b1;
         pslverr  <= setup ? !mapped : pslverr;
         peer     <= next_peer;
         dly_reg  <= next_dly_reg;
         irq_mask <= next_irq_mask;
         irq_stat <= next_irq_stat;
         irq      <= |(next_irq_stat & next_irq_mask);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fsw_pin_float: assert property (soft_start_en |-> !fsw_pin_oe)                         // [R2]
      else $error("frequency strap pin driven after sampling");
   a_slope_held: assert property (soft_start_en && $past(soft_start_en) |-> $stable(slope_sel)) // [R17]
      else $error("slope setting changed while running");
   a_rst_low: assert property (run && !in_reg |=> reset_pin_oe)                             // [R5]
      else $error("reset released while out of regulation");
   a_rst_delay: assert property ($fell(reset_pin_oe) |-> $past(in_reg) && $past(dly_cnt) >= $past(dly_reg)) // [R6]
      else $error("reset released before delay end");
   a_slave_entry: assert property (ms == MS_MASTER ##1 ms == MS_SLAVE |-> latched || $past(fast_cnt) == 4'h9) // [R10]
      else $error("slave entered without ten fast gaps");
   a_slave_hold: assert property (ms == MS_SLAVE && !latched && !ext_rise && half_cnt != 16'h0001
      && gap_cnt >= 16'(HOLD_CYC) |=> ms == MS_REVERT)                                         // [R11]
      else $error("slave kept without fast edges");
   a_revert_pulse: assert property (ms != MS_REVERT ##1 ms == MS_REVERT |-> shared_sync_line_oe && shared_sync_line_o) // [R11]
      else $error("no parting pulse on return to master");
   a_latched_slave: assert property (latched && run |-> ##[0:1] ms == MS_SLAVE)               // [R14]
      else $error("latched slave not kept");
   a_master_drive: assert property (run && ms == MS_MASTER && !latched |-> shared_sync_line_oe) // [R8]
      else $error("master not driving sync line");
   a_phase_zero: assert property (run && ms == MS_SLAVE && !peer && ext_rise |=> sw_start)   // [R13]
      else $error("switching not aligned to reference");

endmodule : rss_top

// >>> rss_peer.sv
`timescale 1ns/1ps
module rss_peer (
   // 0 release, 1 hold low, 2 run the reference
   input  wire logic [1:0] mode,
   // line drive
   output logic            line_o,
   output logic            line_oe
);
   logic lclk = 1'b0;
   // fixed phase against pclk: every edge lands 13 ns before a pclk rising edge
   initial begin
      #37;
      forever #400 lclk = ~lclk;
   end
   // 800 ns period, 400 ns high
   assign line_o  = (mode == 2'h2) ? lclk : 1'b0;
   assign line_oe = (mode != 2'h0);
endmodule : rss_peer

// >>> test_regulator_sync_supervisor.sv
`timescale 1ns/1ps
module test_regulator_sync_supervisor;
   import rss_pkg::*;
   // *****
   // signals
   // *****
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, irq, fpo, fpoe, rpo, rpoe, so, soe, ss, sws, qm, lm, po, poe, line, saw;
   logic [2:0]  fcode = 3'h0, mcode = 3'h0, slope;
   logic [3:0]  sense = 4'h0;
   logic [1:0]  pmode = 2'h0;
   int          n_errors = 0, cmp_count = 0, cyc = 0, n;
   // an external master overpowers the weak on-chip drive; a released line is pulled up
   assign line = poe ? po : (soe ? so : 1'b1);
   initial forever #50 pclk = ~pclk;
   rss_top u_rss_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .fsw_strap_code(fcode), .mode_threshold_strap(mcode), .fsw_pin_o(fpo), .fsw_pin_oe(fpoe),
      .output_sense(sense), .reset_pin_o(rpo), .reset_pin_oe(rpoe), .shared_sync_line_i(line),
      .shared_sync_line_o(so), .shared_sync_line_oe(soe), .soft_start_en(ss), .sw_start(sws),
      .quiet_fixed_frequency_mode(qm), .light_load_saving_mode(lm), .slope_sel(slope));
   rss_peer u_rss_peer (.mode(pmode), .line_o(po), .line_oe(poe));
   // *****
   // tasks
   // *****
   function automatic logic [2:0] exp_mode(input logic [2:0] c);
      logic [15:0] t;
      t = 16'hb4d2;
      return {c[2], t[2*c +: 2]};
   endfunction : exp_mode
   function automatic int fper(input logic [2:0] c);
      int k [8] = '{250, 300, 400, 500, 600, 800, 1000, 1250};
      return 10000 / k[c];
   endfunction : fper
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic finish_test();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // n counts cycles until sw_start, or until the reset pin lets go
   task automatic until_sw(input logic rel);
      for (n = 1; n < 300 && (rel ? rpoe !== 1'b0 : sws !== 1'b1); n++) @(posedge pclk);
   endtask : until_sw
   task automatic rst(input logic [1:0] pm);
      presetn <= 1'b0;
      pmode   <= pm;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({fpoe, fpo}, 2'b11, "fsw_drv");
      chk(pready, 1, "ready");
      chk(ss, 0, "soft");
      for (n = 0; n < 200 && ss !== 1'b1; n++) @(posedge pclk);
      chk(fpoe, 0, "fsw_oe");
   endtask : rst
   // *****
   // main sequence
   // *****
   initial begin
      void'($urandom(35235));
      for (int m = 0; m < 8; m++) begin
         mcode <= 3'(m);
         // last pass keeps the slowest rate so own pulses hide few reference edges later
         fcode <= (m == 7) ? 3'h0 : 3'($urandom_range(6));
         rst(2'h0);
         // light-load outputs follow soft-start by one cycle
         @(posedge pclk);
         chk({lm, qm}, {mcode[2], ~mcode[2]}, "mode");
         chk(slope, fcode, "slope");
         apb(1'b0, A_STATUS, 32'h0);
         chk(rd[5:0], {exp_mode(mcode), fcode}, "status");
         until_sw(1'b0);
         @(posedge pclk);
         until_sw(1'b0);
         chk(n, fper(fcode), "period");
         chk({soe, so}, 2'b11, "sync_drv");
      end
      apb(1'b0, 8'h20, 32'h0);
      chk(pslverr, 1, "unmapped_err");
      chk(rd, 0, "unmapped_rd");
      apb(1'b1, A_DELAY, 32'h5);
      apb(1'b1, A_MASK, 32'h4);
      sense <= 4'h3;
      repeat (20) @(posedge pclk);
      chk({rpoe, rpo}, 2'b10, "below_thr");
      sense <= 4'hf;
      repeat (3) @(posedge pclk);
      sense <= 4'h3;
      repeat (2) @(posedge pclk);
      chk(rpoe, 1, "restart");
      sense <= 4'hf;
      until_sw(1'b1);
      chk(n >= 9 && n <= 11, 1, "delay");
      chk(irq, 1, "irq_pg");
      apb(1'b0, A_IRQ, 32'h0);
      chk(rd[IRQ_PGOOD], 1, "irq_st");
      chk(irq, 0, "irq_clr");
      sense <= 4'h3;
      repeat (4) @(posedge pclk);
      chk(rpoe, 1, "drop");
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_MASK, 32'h3);
      pmode <= 2'h2;
      repeat (56) @(posedge pclk);
      apb(1'b0, A_STATUS, 32'h0);
      chk(rd[8], 0, "early");
      repeat (60) @(posedge pclk);
      apb(1'b0, A_STATUS, 32'h0);
      chk({irq, rd[8]}, 2'b11, "slave");
      apb(1'b0, A_IRQ, 32'h0);
      n = 0;
      // in phase: each start lands while the reference is high
      repeat (160) @(posedge pclk) n += int'(sws && line);
      chk(n >= 19 && n <= 21, 1, "follow");
      apb(1'b1, A_CTRL, 32'h1);
      n = 0;
      // peer slaves: each start lands half a period later, while the reference is low
      repeat (160) @(posedge pclk) n += int'(sws && !line);
      chk(n >= 19 && n <= 21, 1, "half");
      pmode <= 2'h0;
      saw = 1'b0;
      for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge pclk) saw |= soe;
      chk({saw, n >= 70 && n <= 90}, 2'b11, "revert");
      fcode <= 3'h5;
      rst(2'h1);
      pmode <= 2'h0;
      repeat (300) @(posedge pclk);
      apb(1'b0, A_STATUS, 32'h0);
      chk(rd[8:7], 2'b11, "latched");
      until_sw(1'b0);
      @(posedge pclk);
      until_sw(1'b0);
      chk(n, 40, "latch_per");
      finish_test();
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end
endmodule : test_regulator_sync_supervisor
